/* File: servo_loop_pkg.sv */
// Constants and carrier types for the servo loop tuning core.
// Assumes a 250 MHz clock; all settings arrive as plain ports.
package servo_loop_pkg;
    localparam int clk_mhz = 250;
    localparam int tick_us = 100;
    // Cycles per 0.1 ms filter tick
    localparam int cycles_per_tick = clk_mhz * tick_us;
    localparam int ms_us = 1000;
    // Cycles per 1 ms ramp step
    localparam int cycles_per_ms = clk_mhz * ms_us;
    localparam int ramp_ref_rpm = 1000;
    localparam logic [15:0] pos_smooth_max = 16'h7fff;
    localparam logic [15:0] lag_max = 16'h0280;
    localparam logic [15:0] ramp_max = 16'h2710;
    localparam logic [15:0] torque_filt_max = 16'h00fa;
    localparam logic [15:0] torque_filt_default = 16'h0004;
    localparam logic [15:0] vgain_min = 16'h0001;
    localparam logic [15:0] vgain_max = 16'h09c4;
    localparam logic [15:0] vgain_default = 16'h00b4;
    localparam logic [15:0] itime_min = 16'h0001;
    localparam logic [15:0] itime_max = 16'h1400;
    localparam logic [15:0] itime_default = 16'h0064;
    localparam logic [15:0] pgain_min = 16'h0001;
    localparam logic [15:0] pgain_max = 16'h03e8;
    localparam logic [15:0] pgain_default = 16'h0028;
    localparam logic [15:0] overflow_min = 16'h0001;
    localparam logic [15:0] overflow_max = 16'h7fff;
    localparam logic [15:0] overflow_default = 16'h0400;
    localparam int overflow_shift = 8;
    localparam logic [15:0] ff_max = 16'h0064;
    localparam logic [15:0] ff_default = 16'h0050;
    localparam logic [15:0] bias_max = 16'h012c;
    localparam int pct_div = 100;
    localparam logic [1:0] mode_speed = 2'h0;
    localparam logic [1:0] mode_position = 2'h1;

    typedef struct packed {
        logic [15:0] pos_ref_smooth_time;
        logic [15:0] first_order_lag_time;
        logic [15:0] accel_ramp_time;
        logic [15:0] decel_ramp_time;
        logic [15:0] torque_filter_time;
        logic [15:0] velocity_loop_gain;
        logic [15:0] velocity_integral_time;
        logic [15:0] position_loop_gain_setting;
        logic [15:0] error_overflow_level;
        logic [15:0] ff_gain;
        logic [15:0] speed_offset_setting;
        logic [15:0] max_speed;
        logic [1:0] control_mode_select;
    } servo_cfg_t;

    typedef enum logic [1:0] {
        st_run = 2'b00,
        st_alarm = 2'b01,
        st_hold = 2'b10
    } alarm_state_t;
endpackage : servo_loop_pkg

/* File: lag_filter.sv */
// First-order lag filter, one update per tick strobe; a tc of zero follows din every cycle.
// Assumes tick comes from the same clock domain.
`timescale 1ns/1ns
`default_nettype none
module lag_filter import servo_loop_pkg::*; #(
    parameter int width = 32
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic ce,
    input wire logic tick,
    input wire logic [15:0] tc,
    input wire logic signed [width-1:0] din,
    output logic signed [width-1:0] dout
);
    logic signed [width-1:0] next_dout;
    logic signed [width+16:0] step;

    always_comb begin
        step = {{17{din[width-1]}}, din} - {{17{dout[width-1]}}, dout};
        next_dout = dout;
        if (tc == 16'h0000) begin
            next_dout = din;
        end else if (tick) begin
            next_dout = dout + width'(step / $signed({1'b0, tc} + 17'sh1));
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            dout <= '0;
        end else if (ce) begin
            dout <= next_dout;
        end
    end
endmodule : lag_filter
`default_nettype wire

/* File: servo_loop_tuning_core.sv */
// Servo loop core: reference smoothing, soft start, PI/P loops, overflow alarm.
// Assumes synchronous configuration inputs; pulse, sign, P-select and alarm clear pins synchronised here.
// Function
// - Smooth position pulses, 0..32767 x0.1ms
// - First-order lag on position, 0..640
// - Speed soft start, accel/decel 0..10000 ms
// - Accel time: standstill to 1000 r/min
// - Decel time: max speed to stop
// - Torque reference low-pass, 0..250, default 4
// - Speed PI gain and integral time
// - Position gain, per 1000, on lagged error into speed target
// - Overflow alarm above setting times 256
// - Feed-forward added, 0..100 percent
// - Low select input gives P-only control
// - Mode 0 analog, mode 1 pulse train
// - Speed bias added in position mode
// - Alarm clear by input, or confirm key in status display mode
`timescale 1ns/1ns
`default_nettype none
module servo_loop_tuning_core import servo_loop_pkg::*; #(
    parameter int width = 32,
    parameter int tick_cycles = cycles_per_tick,
    parameter int ms_cycles = cycles_per_ms
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic ce,
    input wire servo_cfg_t cfg,
    input wire logic signed [15:0] analog_speed_ref,
    input wire logic ref_pulse,
    input wire logic ref_sign,
    input wire logic pi_p_select_input_n,
    input wire logic alarm_clear_input_n,
    input wire logic confirm_key,
    input wire logic status_display_mode,
    input wire logic zero_clamp,
    input wire logic signed [15:0] motor_speed,
    input wire logic motor_pulse,
    input wire logic motor_dir,
    output logic signed [width-1:0] torque_ref,
    output logic signed [width-1:0] speed_cmd,
    output logic signed [width-1:0] position_error,
    output logic overflow_alarm,
    output logic drive_enable
);
    logic [2:0] pin_s1;
    logic [2:0] pin_s2;
    logic pulse_d;
    logic sign_s1;
    logic sign_s2;
    logic [31:0] tick_cnt;
    logic [31:0] ms_cnt;
    logic tick;
    logic ms_tick;
    logic signed [width-1:0] pos_err_raw;
    logic signed [width-1:0] pos_err_smooth;
    logic signed [width-1:0] pos_err_lag;
    logic signed [width-1:0] ramp_speed;
    logic signed [width-1:0] integ;
    logic signed [width-1:0] torque_raw;
    logic signed [width-1:0] next_pos_err_raw;
    logic signed [width-1:0] next_ramp_speed;
    logic signed [width-1:0] next_integ;
    logic signed [width-1:0] next_speed_cmd;
    logic signed [width-1:0] next_torque_raw;
    logic signed [width-1:0] target;
    logic signed [width-1:0] step;
    logic signed [width-1:0] verr;
    logic [31:0] next_tick_cnt;
    logic [31:0] next_ms_cnt;
    alarm_state_t state;
    alarm_state_t next_state;
    logic pulse_edge;
    logic pos_mode;
    logic p_only;
    logic alarm_clear;

    // Two-flop synchronisers for pulse, P-select and alarm clear pins
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            pin_s1 <= 3'h6;
            pin_s2 <= 3'h6;
            pulse_d <= 1'b0;
            sign_s1 <= 1'b0;
            sign_s2 <= 1'b0;
        end else if (ce) begin
            pin_s1 <= {alarm_clear_input_n, pi_p_select_input_n, ref_pulse};
            pin_s2 <= pin_s1;
            pulse_d <= pin_s2[0];
            // Sign kept in step with the pulse synchroniser
            sign_s1 <= ref_sign;
            sign_s2 <= sign_s1;
        end
    end

    assign pulse_edge = pin_s2[0] & ~pulse_d;
    assign pos_mode = (cfg.control_mode_select == mode_position);
    assign p_only = ~pin_s2[1] & (cfg.control_mode_select <= mode_position);
    assign alarm_clear = ~pin_s2[2] | (confirm_key & status_display_mode);
    assign tick = (tick_cnt == 32'(tick_cycles - 1));
    assign ms_tick = (ms_cnt == 32'(ms_cycles - 1));

    always_comb begin
        next_tick_cnt = tick ? 32'h0 : tick_cnt + 32'h1;
        next_ms_cnt = ms_tick ? 32'h0 : ms_cnt + 32'h1;
        // Position error counter: reference in, feedback out
        next_pos_err_raw = pos_err_raw;
        if (pos_mode && pulse_edge) begin
            next_pos_err_raw = sign_s2 ? next_pos_err_raw - 1 : next_pos_err_raw + 1;
        end
        if (pos_mode && motor_pulse) begin
            next_pos_err_raw = motor_dir ? next_pos_err_raw + 1 : next_pos_err_raw - 1;
        end
        if (!pos_mode || state != st_run) begin
            next_pos_err_raw = '0;
        end
        // Alarm state
        next_state = state;
        case (state)
            st_run: begin
                if (pos_mode && (pos_err_raw > $signed(width'({cfg.error_overflow_level, 8'h00})) ||
                        -pos_err_raw > $signed(width'({cfg.error_overflow_level, 8'h00})))) begin
                    next_state = st_alarm;
                end
            end
            st_alarm: begin
                if (alarm_clear) begin
                    next_state = st_hold;
                end
            end
            st_hold: begin
                if (!alarm_clear) begin
                    next_state = st_run;
                end
            end
            default: next_state = st_run;
        endcase
        // Speed target: position loop with feed-forward and bias, or analog
        if (pos_mode) begin
            target = width'(pos_err_lag * $signed({1'b0, cfg.position_loop_gain_setting})
                / $signed(width'(ms_us)));
            target = target + width'(motor_speed * $signed({1'b0, cfg.ff_gain})
                / $signed(width'(pct_div)));
            if (target != '0) begin
                target = target + (target[width-1] ? -$signed({1'b0, cfg.speed_offset_setting})
                    : $signed({1'b0, cfg.speed_offset_setting}));
            end
        end else if (zero_clamp) begin
            target = '0;
        end else begin
            target = width'(analog_speed_ref);
        end
        // Soft start: one linear step per ms
        next_ramp_speed = ramp_speed;
        step = '0;
        // Magnitude rises when leaving zero or moving away from it on one side
        if (target != ramp_speed && (ramp_speed == '0 ||
                (target[width-1] == ramp_speed[width-1]
                && (target > ramp_speed) == !ramp_speed[width-1]))) begin
            step = (cfg.accel_ramp_time == 16'h0) ? width'(ramp_ref_rpm)
                : width'(ramp_ref_rpm / cfg.accel_ramp_time);
        end else begin
            step = (cfg.decel_ramp_time == 16'h0) ? width'(cfg.max_speed)
                : width'(cfg.max_speed / cfg.decel_ramp_time);
        end
        if (step == '0) begin
            step = width'(1);
        end
        if (cfg.accel_ramp_time == 16'h0 && cfg.decel_ramp_time == 16'h0) begin
            next_ramp_speed = target;
        end else if (ms_tick) begin
            if (target > ramp_speed) begin
                next_ramp_speed = (target - ramp_speed > step) ? ramp_speed + step : target;
            end else if (target < ramp_speed) begin
                next_ramp_speed = (ramp_speed - target > step) ? ramp_speed - step : target;
            end
        end
        next_speed_cmd = ramp_speed;
        // Speed PI loop
        verr = ramp_speed - width'(motor_speed);
        next_integ = integ;
        if (p_only || state != st_run) begin
            next_integ = '0;
        end else if (ms_tick) begin
            next_integ = integ + width'(verr / $signed({1'b0, cfg.velocity_integral_time}));
        end
        next_torque_raw = width'((verr + integ) * $signed({1'b0, cfg.velocity_loop_gain}));
        if (state != st_run) begin
            next_torque_raw = '0;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            tick_cnt <= 32'h0;
            ms_cnt <= 32'h0;
            pos_err_raw <= '0;
            state <= st_run;
            ramp_speed <= '0;
            integ <= '0;
            speed_cmd <= '0;
            torque_raw <= '0;
        end else if (ce) begin
            tick_cnt <= next_tick_cnt;
            ms_cnt <= next_ms_cnt;
            pos_err_raw <= next_pos_err_raw;
            state <= next_state;
            ramp_speed <= next_ramp_speed;
            integ <= next_integ;
            speed_cmd <= next_speed_cmd;
            torque_raw <= next_torque_raw;
        end
    end

    // Position reference smoothing then first-order lag
    lag_filter #(.width(width)) u_pos_smooth (
        .clk(clk),
        .arst_n(arst_n),
        .ce(ce),
        .tick(tick),
        .tc(cfg.pos_ref_smooth_time),
        .din(pos_err_raw),
        .dout(pos_err_smooth)
    );

    lag_filter #(.width(width)) u_pos_lag (
        .clk(clk),
        .arst_n(arst_n),
        .ce(ce),
        .tick(tick),
        .tc(cfg.first_order_lag_time),
        .din(pos_err_smooth),
        .dout(pos_err_lag)
    );

    lag_filter #(.width(width)) u_torque (
        .clk(clk),
        .arst_n(arst_n),
        .ce(ce),
        .tick(tick),
        .tc(cfg.torque_filter_time),
        .din(torque_raw),
        .dout(torque_ref)
    );

    assign position_error = pos_err_raw;
    assign overflow_alarm = (state != st_run);
    assign drive_enable = (state == st_run);
endmodule : servo_loop_tuning_core
`default_nettype wire

/* File: servo_loop_monitor.sv */
// Checker for the servo loop core: pulse count, overflow alarm, ramp.
// Assumes a bind into servo_loop_tuning_core; one clock domain.
`timescale 1ns/1ns
`default_nettype none
module servo_loop_monitor import servo_loop_pkg::*; #(
    parameter int width = 32
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic ce,
    input wire servo_cfg_t cfg,
    input wire logic signed [15:0] analog_speed_ref,
    input wire logic ref_pulse,
    input wire logic ref_sign,
    input wire logic alarm_clear_input_n,
    input wire logic confirm_key,
    input wire logic status_display_mode,
    input wire logic zero_clamp,
    input wire logic motor_pulse,
    input wire logic signed [width-1:0] speed_cmd,
    input wire logic signed [width-1:0] position_error,
    input wire logic overflow_alarm,
    input wire logic drive_enable
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    logic signed [width-1:0] limit;
    logic over, pos_mode, spd_mode, no_clear;
    assign limit = width'({cfg.error_overflow_level, 8'h00});
    assign over = position_error > limit || position_error < -limit;
    assign pos_mode = ce && cfg.control_mode_select == mode_position;
    assign spd_mode = ce && cfg.control_mode_select == mode_speed && cfg.ff_gain == 16'h0000
        && !zero_clamp;
    assign no_clear = alarm_clear_input_n && !(confirm_key && status_display_mode);
    sequence quiet_edge;
        $rose(ref_pulse) && !$past(ref_pulse, 2) && !$past(ref_pulse, 3);
    endsequence
    sequence pos_steady;
        (pos_mode && !overflow_alarm && !motor_pulse && cfg.pos_ref_smooth_time == 16'h0000
            && cfg.first_order_lag_time == 16'h0000) [*4];
    endsequence
    pulse_count_a: assert property (
        quiet_edge ##0 pos_steady |->
        position_error == $past(position_error, 3) + ($past(ref_sign, 3) ? -1 : 1))
        else $error("pulse not counted after three cycles");
    drive_inv_a: assert property (drive_enable != overflow_alarm)
        else $error("drive enable not inverse of alarm");
    alarm_hold_a: assert property ((overflow_alarm && no_clear) [*6] |=> overflow_alarm)
        else $error("alarm dropped without clear");
    alarm_raise_a: assert property (
        pos_mode && over && no_clear && !overflow_alarm |=> overflow_alarm)
        else $error("overflow not alarmed");
    alarm_cause_a: assert property ($rose(overflow_alarm) |-> $past(over))
        else $error("alarm without overflow");
    err_zero_a: assert property (
        (ce && cfg.control_mode_select == mode_speed) [*4] |-> position_error == '0)
        else $error("error counter moved in speed mode");
    ramp_bypass_a: assert property (
        (spd_mode && cfg.accel_ramp_time == 16'h0000 && cfg.decel_ramp_time == 16'h0000
            && $stable(analog_speed_ref)) [*4] |-> speed_cmd == analog_speed_ref)
        else $error("unramped speed not followed");
    ramp_slope_a: assert property (
        spd_mode && $past(spd_mode) && cfg.accel_ramp_time != 16'h0000
        && $past(speed_cmd) >= 0 |->
        int'(speed_cmd - $past(speed_cmd)) <= ramp_ref_rpm / int'(cfg.accel_ramp_time) + 1)
        else $error("acceleration too steep");
endmodule : servo_loop_monitor
bind servo_loop_tuning_core servo_loop_monitor #(.width(width)) mon (
    .clk, .arst_n, .ce, .cfg, .analog_speed_ref, .ref_pulse, .ref_sign,
    .alarm_clear_input_n, .confirm_key, .status_display_mode, .zero_clamp,
    .motor_pulse, .speed_cmd, .position_error, .overflow_alarm, .drive_enable
);
`default_nettype wire

/* File: host_pulse_source.sv */
// Host controller model: pulse train with a sign level.
// Assumes start is raised for one cycle with count and dir held.
`timescale 1ns/1ns
`default_nettype none
module host_pulse_source (
    input wire logic clk,
    input wire logic start,
    input wire logic [9:0] count,
    input wire logic dir,
    input wire logic [3:0] gap,
    output logic ref_pulse,
    output logic ref_sign,
    output logic busy
);
    initial begin
        ref_pulse = 1'b0;
        ref_sign = 1'b0;
        busy = 1'b0;
    end
    always @(posedge clk) begin
        if (start) begin
            @(negedge clk);
            busy = 1'b1;
            ref_sign = dir;
            repeat (count) begin
                repeat (gap) @(negedge clk);
                ref_pulse = 1'b1;
                repeat (gap) @(negedge clk);
                ref_pulse = 1'b0;
            end
            @(negedge clk);
            // Sign no longer held once the train is over
            ref_sign = !dir;
            busy = 1'b0;
        end
    end
endmodule : host_pulse_source
`default_nettype wire

/* File: servo_loop_tuning_core_tb_top.sv */
// Bench for the servo loop core: pulse count, alarm, ramp, P-only.
// Assumes the host model drives the pulse pins; inputs change at falling edges.
`timescale 1ns/1ns
`default_nettype none
module servo_loop_tuning_core_tb_top import servo_loop_pkg::*; ;
    logic clk, arst_n, ce, pi_p_select_input_n, alarm_clear_input_n, confirm_key;
    logic status_display_mode, zero_clamp, ref_pulse, ref_sign, start, dir, busy;
    logic overflow_alarm, drive_enable, motor_pulse, motor_dir;
    logic [9:0] count;
    logic signed [15:0] analog_speed_ref;
    logic signed [15:0] motor_speed;
    logic signed [31:0] torque_ref, speed_cmd, position_error, held;
    servo_cfg_t cfg;
    int errors, samples_checked;
    servo_loop_tuning_core #(.width(32), .tick_cycles(4), .ms_cycles(8)) uut (
        .clk, .arst_n, .ce, .cfg, .analog_speed_ref, .ref_pulse, .ref_sign,
        .pi_p_select_input_n, .alarm_clear_input_n, .confirm_key, .status_display_mode,
        .zero_clamp, .motor_speed, .motor_pulse, .motor_dir,
        .torque_ref, .speed_cmd, .position_error, .overflow_alarm, .drive_enable
    );
    host_pulse_source host (.clk, .start, .count, .dir, .gap(4'h3), .ref_pulse, .ref_sign,
        .busy);
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        samples_checked++;
        if (seen !== want) begin
            errors++;
            $display("MISMATCH %0t seen %h want %h", $time, seen, want);
        end
    endtask : check
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask : cyc
    task automatic send(input int n, input logic d);
        count = 10'(n);
        dir = d;
        start = 1'b1;
        cyc(1);
        start = 1'b0;
        cyc(2);
        for (int i = 0; i < 4000 && busy; i++) cyc(1);
        check(busy, 1'b0);
        cyc(6);
    endtask : send
    task automatic t_count;
        send(5, 1'b0);
        check(position_error, 5);
        send(3, 1'b1);
        check(position_error, 2);
        motor_pulse = 1'b1;
        cyc(1);
        motor_pulse = 1'b0;
        cyc(2);
        check(position_error, 1);
        cfg.control_mode_select = mode_speed;
        send(3, 1'b0);
        check(position_error, 0);
        cfg.control_mode_select = mode_position;
    endtask : t_count
    task automatic t_alarm;
        for (int i = 0; i < 2; i++) begin
            cfg.error_overflow_level = overflow_min;
            send(256, 1'b0);
            check(overflow_alarm, 0);
            send(1, 1'b0);
            check(overflow_alarm, 1);
            check(drive_enable, 0);
            cyc(20);
            check(overflow_alarm, 1);
            cfg.error_overflow_level = overflow_max;
            alarm_clear_input_n = i[0];
            confirm_key = i[0];
            status_display_mode = i[0];
            cyc(4);
            check(overflow_alarm, 1);
            alarm_clear_input_n = 1'b1;
            confirm_key = 1'b0;
            cyc(8);
            check(overflow_alarm, 0);
            check(drive_enable, 1);
        end
    endtask : t_alarm
    task automatic t_ramp;
        cfg.control_mode_select = mode_speed;
        analog_speed_ref = 16'sh01f4;
        cyc(6);
        check(speed_cmd, 32'h0000_01f4);
        zero_clamp = 1'b1;
        cyc(6);
        check(speed_cmd, 0);
        zero_clamp = 1'b0;
        analog_speed_ref = 16'sh0000;
        cfg.accel_ramp_time = 16'h0004;
        cfg.decel_ramp_time = 16'h0008;
        cyc(6);
        analog_speed_ref = 16'sh03e8;
        cyc(16);
        check(speed_cmd > 0 && speed_cmd < 32'sh0000_03e8, 1);
        held = speed_cmd;
        ce = 1'b0;
        cyc(20);
        check(speed_cmd, held);
        ce = 1'b1;
        cyc(40);
        check(speed_cmd, 32'h0000_03e8);
        analog_speed_ref = 16'sh0000;
        cyc(12);
        check(speed_cmd > 0, 1);
        cyc(40);
        check(speed_cmd, 0);
        cfg.accel_ramp_time = 16'h0000;
        cfg.decel_ramp_time = 16'h0000;
        cyc(4);
        check(torque_ref != 0, 1);
        pi_p_select_input_n = 1'b0;
        cyc(30);
        check(torque_ref, 0);
        pi_p_select_input_n = 1'b1;
    endtask : t_ramp
    task automatic print_verdict;
        if (errors == 0 && samples_checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : print_verdict
    initial begin
        #200000;
        errors++;
        print_verdict();
    end
    initial begin
        {arst_n, start, dir, count, zero_clamp, confirm_key, status_display_mode} = '0;
        {motor_pulse, motor_dir} = 2'h0;
        motor_speed = 16'sh0000;
        {ce, pi_p_select_input_n, alarm_clear_input_n} = 3'h7;
        analog_speed_ref = 16'sh0000;
        errors = 0;
        samples_checked = 0;
        cfg = '0;
        cfg.velocity_loop_gain = vgain_default;
        cfg.velocity_integral_time = itime_default;
        cfg.position_loop_gain_setting = pgain_default;
        cfg.error_overflow_level = overflow_default;
        cfg.max_speed = 16'h07d0;
        cfg.ff_gain = 16'h0000;
        cfg.control_mode_select = mode_position;
        cyc(8);
        check(drive_enable, 1);
        arst_n = 1'b1;
        cyc(2);
        t_count();
        t_alarm();
        t_ramp();
        print_verdict();
    end
endmodule : servo_loop_tuning_core_tb_top
`default_nettype wire
